//--- hw/hvm_pkg.sv
package hvm_pkg;

   // ==========================================================
   // bus geometry
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;

   // ==========================================================
   // register byte offsets
   localparam logic [7:0] OFS_MEAS_CTRL  = 8'h00;
   localparam logic [7:0] OFS_PIN_FUNC   = 8'h04;
   localparam logic [7:0] OFS_PULL_CFG   = 8'h08;
   localparam logic [7:0] OFS_WAKE_CFG   = 8'h0C;
   localparam logic [7:0] OFS_WAKE_STAT0 = 8'h10;
   localparam logic [7:0] OFS_WAKE_STAT1 = 8'h14;
   localparam logic [7:0] OFS_LEVEL_STAT = 8'h18;
   localparam logic [7:0] OFS_MODE_CMD   = 8'h1C;
   localparam logic [7:0] OFS_IRQ_STAT   = 8'h20;
   localparam logic [7:0] OFS_IRQ_MASK   = 8'h24;

   // ==========================================================
   // field positions
   localparam int unsigned BIT_MEAS       = 0;  // measure_route_enable
   localparam int unsigned FUNC_LSB       = 0;  // pin function code
   localparam int unsigned FUNC_MSB       = 2;
   localparam int unsigned BIT_FO_TEST    = 4;  // fail_output_test
   localparam int unsigned BIT_SW_ON      = 5;  // side switch on
   localparam int unsigned PULL_LSB       = 0;
   localparam int unsigned PULL_MSB       = 1;
   localparam int unsigned BIT_WK_SENSE   = 0;  // sense_wake_enable
   localparam int unsigned BIT_WK_PIN     = 1;  // pin_as_wake_input
   localparam int unsigned BIT_WK_OTHER   = 2;  // any other wake source
   localparam int unsigned CMD_LSB        = 0;
   localparam int unsigned CMD_MSB        = 1;
   localparam int unsigned BIT_LVL_SENSE  = 0;
   localparam int unsigned BIT_LVL_PIN    = 1;
   localparam int unsigned IRQ_W          = 3;
   localparam int unsigned IRQ_CMD_ERR    = 0;  // command error flag
   localparam int unsigned IRQ_SENSE_WAKE = 1;
   localparam int unsigned IRQ_PIN_WAKE   = 2;

   // ==========================================================
   // codes
   localparam logic [2:0] FUNC_OFF       = 3'h0;
   localparam logic [2:0] FUNC_FAIL      = 3'h1;
   localparam logic [2:0] FUNC_WAKE      = 3'h2;
   localparam logic [2:0] FUNC_LOW_SIDE  = 3'h3;
   localparam logic [2:0] FUNC_HIGH_SIDE = 3'h4;
   localparam logic [1:0] PULL_NONE      = 2'h0;
   localparam logic [1:0] PULL_DOWN      = 2'h1;
   localparam logic [1:0] PULL_UP        = 2'h2;
   localparam logic [1:0] PULL_AUTO      = 2'h3;
   localparam logic [1:0] CMD_SLEEP      = 2'h1;

   // operating mode reported by the mode controller
   typedef enum logic [2:0] {
      HVM_INIT      = 3'h0,
      HVM_NORMAL    = 3'h1,
      HVM_STOP      = 3'h3,
      HVM_SLEEP     = 3'h2,
      HVM_RESTART   = 3'h6,
      HVM_FAIL_SAFE = 3'h7
   } hvm_mode_e;

endpackage

//--- hw/hvm_sticky.sv
`timescale 1ns/1ns
module hvm_sticky
   import hvm_pkg::*;
#(
   parameter int unsigned W = 1
) (
   input  logic         pclk,
   input  logic         presetn,
   input  logic [W-1:0] set,
   input  logic [W-1:0] clr,
   output logic [W-1:0] q
);

   logic [W-1:0] flag_q;
   logic [W-1:0] flag_d;

   // ==========================================================
   // sticky flags, a set in the clearing cycle wins
   always_comb begin
      flag_d = (flag_q & ~clr) | set;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_q <= '0;
      end else begin
         flag_q <= flag_d;
      end
   end

   assign q = flag_q;

endmodule

//--- hw/hvm_pin_watch.sv
`timescale 1ns/1ns
module hvm_pin_watch
   import hvm_pkg::*;
(
   input  logic pclk,
   input  logic presetn,
   input  logic pin_async,
   input  logic gate,
   output logic level,
   output logic change
);

   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic lvl_q;
   logic lvl_d;
   logic chg_q;
   logic chg_d;

   // ==========================================================
   // accept a new level once stages two and three agree
   always_comb begin
      lvl_d = lvl_q;
      chg_d = 1'b0;
      if (s2_q == s3_q) begin
         lvl_d = s3_q;
         chg_d = (s3_q != lvl_q) && !gate;  // gated path reports nothing
      end
   end

   // three-stage synchroniser plus filtered level
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q  <= 1'b0;
         s2_q  <= 1'b0;
         s3_q  <= 1'b0;
         lvl_q <= 1'b0;
         chg_q <= 1'b0;
      end else begin
         s1_q  <= pin_async;
         s2_q  <= s1_q;
         s3_q  <= s2_q;
         lvl_q <= lvl_d;
         chg_q <= chg_d;
      end
   end

   assign level  = lvl_q;
   assign change = chg_q;

endmodule

//--- hw/hvm_route_ctrl.sv
`timescale 1ns/1ns
module hvm_route_ctrl
   import hvm_pkg::*;
(
   input  logic              pclk,
   input  logic              presetn,
   input  logic              psel,
   input  logic              penable,
   input  logic              pwrite,
   input  logic [ADDR_W-1:0] paddr,
   input  logic [DATA_W-1:0] pwdata,
   output logic [DATA_W-1:0] prdata,
   output logic              pready,
   output logic              pslverr,
   input  hvm_mode_e         sbc_mode,
   input  logic              fail_signal,
   input  logic              hv_sense_input,
   input  logic              fail_gp_pin_i,
   output logic              fail_gp_pin_o,
   output logic              fail_gp_pin_oe,
   output logic              route_switch_close,
   output logic              sense_pull_up_en,
   output logic              sense_pull_down_en,
   output logic              pin_pull_down_en,
   output logic              sleep_req,
   output logic              restart_req,
   output logic              irq
);

   // ==========================================================
   // address decode
   function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
      case (a)
         OFS_MEAS_CTRL, OFS_PIN_FUNC, OFS_PULL_CFG, OFS_WAKE_CFG,
         OFS_WAKE_STAT0, OFS_WAKE_STAT1, OFS_LEVEL_STAT, OFS_MODE_CMD,
         OFS_IRQ_STAT, OFS_IRQ_MASK: reg_hit = 1'b1;
         default: reg_hit = 1'b0;
      endcase
   endfunction

   logic              wr_en;
   logic              rd_setup;
   logic              meas_q,    meas_d;
   logic [2:0]        func_q,    func_d;
   logic              fo_test_q, fo_test_d;
   logic              sw_on_q,   sw_on_d;
   logic [1:0]        pull_q,    pull_d;
   logic [2:0]        wcfg_q,    wcfg_d;
   logic [IRQ_W-1:0]  mask_q,    mask_d;
   logic [1:0]        lvl_q,     lvl_d;
   logic [DATA_W-1:0] rdata_q,   rdata_d;
   logic              sleep_q,   sleep_d;
   logic              restart_q, restart_d;
   logic              route_q,   route_d;
   logic              pin_o_q,   pin_o_d;
   logic              pin_oe_q,  pin_oe_d;
   logic              pu_q,      pu_d;
   logic              pd_q,      pd_d;
   logic              ppd_q,     ppd_d;
   logic              cmd_err;
   logic              sense_lvl, sense_chg;
   logic              pin_lvl,   pin_chg;
   logic              sense_wk,  pin_wk;
   logic              wstat0,    wstat1;
   logic [IRQ_W-1:0]  irq_stat;
   logic [IRQ_W-1:0]  irq_set;

   // ==========================================================
   // bus strobes, one wait-free access phase
   assign wr_en    = psel && penable && pwrite;
   assign rd_setup = psel && !penable && !pwrite;
   assign pready   = 1'b1;
   assign pslverr  = psel && penable && !reg_hit(paddr);
   assign prdata   = rdata_q;

   // ==========================================================
   // input watchers, gated while measuring
   hvm_pin_watch u_sense_watch (
      .pclk      (pclk),
      .presetn   (presetn),
      .pin_async (hv_sense_input),
      .gate      (meas_q),
      .level     (sense_lvl),
      .change    (sense_chg)
   );

   hvm_pin_watch u_pin_watch (
      .pclk      (pclk),
      .presetn   (presetn),
      .pin_async (fail_gp_pin_i),
      .gate      (meas_q),
      .level     (pin_lvl),
      .change    (pin_chg)
   );

   // wake events only with measurement off
   assign sense_wk = sense_chg && wcfg_q[BIT_WK_SENSE] && !meas_q;
   assign pin_wk   = pin_chg && wcfg_q[BIT_WK_PIN] && !meas_q;

   // ==========================================================
   // configuration writes and sleep command check
   always_comb begin
      meas_d    = meas_q;
      func_d    = func_q;
      fo_test_d = fo_test_q;
      sw_on_d   = sw_on_q;
      pull_d    = pull_q;
      wcfg_d    = wcfg_q;
      mask_d    = mask_q;
      cmd_err   = 1'b0;
      sleep_d   = 1'b0;
      restart_d = 1'b0;
      if (wr_en) begin
         case (paddr)
            OFS_MEAS_CTRL: begin
               if (pwdata[BIT_MEAS] && !meas_q && (func_q != FUNC_OFF)) begin
                  cmd_err = 1'b1;
               end else begin
                  meas_d = pwdata[BIT_MEAS];
               end
            end
            OFS_PIN_FUNC: begin
               func_d    = pwdata[FUNC_MSB:FUNC_LSB];
               fo_test_d = pwdata[BIT_FO_TEST];
               sw_on_d   = pwdata[BIT_SW_ON];
               if (meas_q && ({sw_on_d, fo_test_d, func_d} !=
                              {sw_on_q, fo_test_q, func_q})) begin
                  cmd_err = 1'b1;
               end
            end
            OFS_PULL_CFG: begin
               pull_d = pwdata[PULL_MSB:PULL_LSB];
            end
            OFS_WAKE_CFG: begin
               wcfg_d = pwdata[BIT_WK_OTHER:BIT_WK_SENSE];
            end
            OFS_IRQ_MASK: begin
               mask_d = pwdata[IRQ_W-1:0];
            end
            OFS_MODE_CMD: begin
               if (pwdata[CMD_MSB:CMD_LSB] == CMD_SLEEP) begin
                  if (meas_q && !wcfg_q[BIT_WK_OTHER] &&
                      (wcfg_q[BIT_WK_SENSE] || wcfg_q[BIT_WK_PIN])) begin
                     cmd_err   = 1'b1;
                     restart_d = 1'b1;
                  end else begin
                     sleep_d = 1'b1;
                  end
               end
            end
            default: begin
            end
         endcase
      end
   end

   // ==========================================================
   // pin drive, pulls, switch and level status
   always_comb begin
      pin_o_d  = 1'b0;
      pin_oe_d = 1'b0;
      pu_d     = 1'b0;
      pd_d     = 1'b0;
      ppd_d    = 1'b0;
      route_d  = meas_q && (sbc_mode == HVM_NORMAL);
      lvl_d    = lvl_q;
      if (!meas_q) begin
         lvl_d = {pin_lvl, sense_lvl};
         case (func_q)
            FUNC_FAIL: begin
               pin_oe_d = fail_signal || fo_test_q;       // low-active fail line
            end
            FUNC_LOW_SIDE: begin
               pin_oe_d = sw_on_q;
            end
            FUNC_HIGH_SIDE: begin
               pin_oe_d = sw_on_q;
               pin_o_d  = 1'b1;
            end
            FUNC_WAKE: begin
               ppd_d = 1'b1;
            end
            default: begin
            end
         endcase
         case (pull_q)
            PULL_DOWN: pd_d = 1'b1;
            PULL_UP:   pu_d = 1'b1;
            PULL_AUTO: begin
               pu_d = sense_lvl;                          // hold the present level
               pd_d = !sense_lvl;
            end
            default: begin
            end
         endcase
      end
   end

   // read data captured in the setup cycle
   always_comb begin
      rdata_d = rdata_q;
      if (rd_setup) begin
         rdata_d = '0;
         case (paddr)
            OFS_MEAS_CTRL:  rdata_d[BIT_MEAS] = meas_q;
            OFS_PIN_FUNC: begin
               rdata_d[FUNC_MSB:FUNC_LSB] = func_q;
               rdata_d[BIT_FO_TEST]       = fo_test_q;
               rdata_d[BIT_SW_ON]         = sw_on_q;
            end
            OFS_PULL_CFG:   rdata_d[PULL_MSB:PULL_LSB] = pull_q;
            OFS_WAKE_CFG:   rdata_d[BIT_WK_OTHER:BIT_WK_SENSE] = wcfg_q;
            OFS_WAKE_STAT0: rdata_d[0] = wstat0;
            OFS_WAKE_STAT1: rdata_d[0] = wstat1;
            OFS_LEVEL_STAT: rdata_d[BIT_LVL_PIN:BIT_LVL_SENSE] = lvl_q;
            OFS_MODE_CMD:   rdata_d[2:0] = sbc_mode;
            OFS_IRQ_STAT:   rdata_d[IRQ_W-1:0] = irq_stat;
            OFS_IRQ_MASK:   rdata_d[IRQ_W-1:0] = mask_q;
            default: begin
            end
         endcase
      end
   end

   // ==========================================================
   // state registers, everything off after reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meas_q    <= 1'b0;
         func_q    <= FUNC_OFF;
         fo_test_q <= 1'b0;
         sw_on_q   <= 1'b0;
         pull_q    <= PULL_NONE;
         wcfg_q    <= '0;
         mask_q    <= '0;
         lvl_q     <= '0;
         rdata_q   <= '0;
         sleep_q   <= 1'b0;
         restart_q <= 1'b0;
         route_q   <= 1'b0;
         pin_o_q   <= 1'b0;
         pin_oe_q  <= 1'b0;
         pu_q      <= 1'b0;
         pd_q      <= 1'b0;
         ppd_q     <= 1'b0;
      end else begin
         meas_q    <= meas_d;
         func_q    <= func_d;
         fo_test_q <= fo_test_d;
         sw_on_q   <= sw_on_d;
         pull_q    <= pull_d;
         wcfg_q    <= wcfg_d;
         mask_q    <= mask_d;
         lvl_q     <= lvl_d;
         rdata_q   <= rdata_d;
         sleep_q   <= sleep_d;
         restart_q <= restart_d;
         route_q   <= route_d;
         pin_o_q   <= pin_o_d;
         pin_oe_q  <= pin_oe_d;
         pu_q      <= pu_d;
         pd_q      <= pd_d;
         ppd_q     <= ppd_d;
      end
   end

   // ==========================================================
   // sticky status, write one to clear
   hvm_sticky #(.W(1)) u_wake_stat0 (
      .pclk    (pclk),
      .presetn (presetn),
      .set     (sense_wk),
      .clr     (wr_en && (paddr == OFS_WAKE_STAT0) && pwdata[0]),
      .q       (wstat0)
   );

   hvm_sticky #(.W(1)) u_wake_stat1 (
      .pclk    (pclk),
      .presetn (presetn),
      .set     (pin_wk),
      .clr     (wr_en && (paddr == OFS_WAKE_STAT1) && pwdata[0]),
      .q       (wstat1)
   );

   always_comb begin
      irq_set                 = '0;
      irq_set[IRQ_CMD_ERR]    = cmd_err;
      irq_set[IRQ_SENSE_WAKE] = sense_wk;
      irq_set[IRQ_PIN_WAKE]   = pin_wk;
   end

   hvm_sticky #(.W(IRQ_W)) u_irq_stat (
      .pclk    (pclk),
      .presetn (presetn),
      .set     (irq_set),
      .clr     (wr_en && (paddr == OFS_IRQ_STAT) ? pwdata[IRQ_W-1:0] : '0),
      .q       (irq_stat)
   );

   // ==========================================================
   // outputs
   assign irq                = |(irq_stat & mask_q);
   assign route_switch_close = route_q;
   assign fail_gp_pin_o      = pin_o_q;
   assign fail_gp_pin_oe     = pin_oe_q;
   assign sense_pull_up_en   = pu_q;
   assign sense_pull_down_en = pd_q;
   assign pin_pull_down_en   = ppd_q;
   assign sleep_req          = sleep_q;
   assign restart_req        = restart_q;

   // ==========================================================
   // checks
   chk_route_cause: assert property (@(posedge pclk) disable iff (!presetn)
      route_switch_close |-> $past(meas_q) && ($past(sbc_mode) == HVM_NORMAL))
      else $error("switch closed without enable in normal mode");

   chk_route_close: assert property (@(posedge pclk) disable iff (!presetn)
      meas_q && (sbc_mode == HVM_NORMAL) |=> route_switch_close)
      else $error("switch not closed in normal mode");

   chk_pulls_off: assert property (@(posedge pclk) disable iff (!presetn)
      meas_q |=> !sense_pull_up_en && !sense_pull_down_en && !pin_pull_down_en)
      else $error("pull active while measuring");

   chk_wake_frozen: assert property (@(posedge pclk) disable iff (!presetn)
      meas_q |=> !$rose(wstat0) && !$rose(wstat1))
      else $error("wake status set while measuring");

   chk_level_frozen: assert property (@(posedge pclk) disable iff (!presetn)
      meas_q |=> $stable(lvl_q))
      else $error("level status moved while measuring");

   chk_sleep_refused: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en && (paddr == OFS_MODE_CMD) && (pwdata[CMD_MSB:CMD_LSB] == CMD_SLEEP)
      && meas_q && !wcfg_q[BIT_WK_OTHER] && (wcfg_q[BIT_WK_SENSE] || wcfg_q[BIT_WK_PIN])
      |=> restart_req && !sleep_req && irq_stat[IRQ_CMD_ERR] ##1 !restart_req)
      else $error("sleep not turned into restart");

   chk_pin_released: assert property (@(posedge pclk) disable iff (!presetn)
      meas_q |=> !fail_gp_pin_oe)
      else $error("pin driven while measuring");

   chk_func_error: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en && (paddr == OFS_PIN_FUNC) && meas_q
      && (pwdata[FUNC_MSB:FUNC_LSB] != func_q) |=> irq_stat[IRQ_CMD_ERR])
      else $error("function change not flagged");

   chk_meas_refused: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en && (paddr == OFS_MEAS_CTRL) && pwdata[BIT_MEAS] && !meas_q
      && (func_q != FUNC_OFF) |=> !meas_q && irq_stat[IRQ_CMD_ERR])
      else $error("enable accepted with pin function set");

   chk_fail_safe: assert property (@(posedge pclk) disable iff (!presetn)
      meas_q && (sbc_mode == HVM_FAIL_SAFE) && !(wr_en && (paddr == OFS_MEAS_CTRL))
      |=> meas_q && !route_switch_close)
      else $error("fail-safe lost enable or closed switch");

endmodule

//--- test/hvm_adc_model.sv
`timescale 1ns/1ns
// ==========================================================
// converter input behind the external resistor divider
module hvm_adc_model (
   input  logic sense_level,
   input  logic switch_close,
   input  logic pin_o,
   input  logic pin_oe,
   output logic pin_level
);
   // own drive wins, closed switch routes the sense level, else divider pulls low
   assign pin_level = pin_oe ? pin_o : (switch_close ? sense_level : 1'b0);
endmodule

//--- test/test_hv_measure_route_control.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
   $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module test_hv_measure_route_control
   import hvm_pkg::*;
;
   typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] e;} hvm_row_s;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   hvm_mode_e   sbc_mode;
   logic        fail_signal, sense, pin, pin_o, pin_oe, sw, pu, pd, ppd, slp, rst, irq, err;
   int          errors, checks, n_slp, n_rst, i;
   hvm_row_s    rows [18];
   hvm_mode_e   modes [5];
   logic [7:0]  stat_ofs [4];

   hvm_route_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sbc_mode(sbc_mode), .fail_signal(fail_signal),
      .hv_sense_input(sense), .fail_gp_pin_i(pin), .fail_gp_pin_o(pin_o),
      .fail_gp_pin_oe(pin_oe), .route_switch_close(sw), .sense_pull_up_en(pu),
      .sense_pull_down_en(pd), .pin_pull_down_en(ppd), .sleep_req(slp),
      .restart_req(rst), .irq(irq));
   hvm_adc_model u_adc (.sense_level(sense), .switch_close(sw), .pin_o(pin_o),
      .pin_oe(pin_oe), .pin_level(pin));

   // ==========================================================
   // clock and pulse counters
   initial begin
      pclk = 0;
      forever #20 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      if (slp === 1'b1) n_slp++;
      if (rst === 1'b1) n_rst++;
   end

   // ==========================================================
   // helpers
   task finish_test;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task tick(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask
   // one apb transfer, held until pready is seen high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel    <= 1;
      penable <= 0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) begin
         errors++;
         finish_test();
      end
      rd  = prdata;
      err = pslverr;
      psel    <= 0;
      penable <= 0;
   endtask
   task rchk(input logic [7:0] a, input logic [31:0] e);
      apb(0, a, 0);
      `CHK("read", e, rd)
   endtask

   // ==========================================================
   // main sequence
   initial begin
      psel        = 0;
      penable     = 0;
      pwrite      = 0;
      paddr       = 0;
      pwdata      = 0;
      presetn     = 0;
      sbc_mode    = HVM_NORMAL;
      fail_signal = 1;
      sense       = 0;
      errors      = 0;
      checks      = 0;
      n_slp       = 0;
      n_rst       = 0;
      rows = '{'{0,OFS_MEAS_CTRL,0,0}, '{1,OFS_PIN_FUNC,2,0}, '{1,OFS_MEAS_CTRL,1,0},
         '{0,OFS_MEAS_CTRL,0,0}, '{0,OFS_IRQ_STAT,0,1}, '{1,OFS_IRQ_STAT,1,0},
         '{1,OFS_PIN_FUNC,0,0}, '{1,OFS_MEAS_CTRL,1,0}, '{0,OFS_MEAS_CTRL,0,1},
         '{1,OFS_PIN_FUNC,1,0}, '{0,OFS_PIN_FUNC,0,1}, '{0,OFS_IRQ_STAT,0,1},
         '{1,OFS_IRQ_STAT,1,0}, '{1,OFS_PIN_FUNC,1,0}, '{0,OFS_IRQ_STAT,0,0},
         '{1,OFS_WAKE_CFG,3,0}, '{0,OFS_WAKE_CFG,0,3}, '{1,OFS_PULL_CFG,2,0}};
      modes = '{HVM_STOP, HVM_SLEEP, HVM_RESTART, HVM_INIT, HVM_FAIL_SAFE};
      stat_ofs = '{OFS_LEVEL_STAT, OFS_WAKE_STAT0, OFS_WAKE_STAT1, OFS_IRQ_STAT};
      repeat (6) @(posedge pclk);
      presetn <= 1;
      tick(1);
      `CHK("switch", 1'b0, sw)
      `CHK("pulls", 3'h0, {pu, pd, ppd})
      // refused enable, stored writes, error flag, readback of wake bits
      for (i = 0; i < 18; i++) begin
         apb(rows[i].wr, rows[i].a, rows[i].d);
         if (!rows[i].wr) `CHK("row", rows[i].e, rd)
      end
      $display("test table done");
      tick(2);
      `CHK("switch", 1'b1, sw)
      `CHK("fail drive", 1'b0, pin_oe)
      `CHK("pulls", 3'h0, {pu, pd, ppd})
      @(posedge pclk);
      sense <= 1;
      tick(8);
      `CHK("routed", 1'b1, pin)
      for (i = 0; i < 4; i++) rchk(stat_ofs[i], 0);
      for (i = 0; i < 5; i++) begin
         sbc_mode <= modes[i];
         tick(2);
         `CHK("switch", 1'b0, sw)
         rchk(OFS_MEAS_CTRL, 1);
      end
      sbc_mode <= HVM_NORMAL;
      tick(2);
      `CHK("switch", 1'b1, sw)
      $display("test modes done");
      apb(1, OFS_MODE_CMD, CMD_SLEEP);
      tick(3);
      `CHK("restart", 2'h1, 2'(n_rst))
      `CHK("sleep", 2'h0, 2'(n_slp))
      rchk(OFS_IRQ_STAT, 1);
      apb(1, OFS_IRQ_STAT, 1);
      apb(1, OFS_WAKE_CFG, 7);
      apb(1, OFS_MODE_CMD, CMD_SLEEP);
      tick(3);
      `CHK("sleep", 2'h1, 2'(n_slp))
      $display("test sleep done");
      apb(1, OFS_WAKE_CFG, 1);
      apb(1, OFS_MEAS_CTRL, 0);
      tick(2);
      `CHK("fail drive", 2'h2, {pin_oe, pin_o})
      apb(1, OFS_PIN_FUNC, 0);
      tick(8);
      `CHK("pull up", 1'b1, pu)
      rchk(OFS_LEVEL_STAT, 1);
      sense <= 0;
      tick(8);
      rchk(OFS_WAKE_STAT0, 1);
      rchk(OFS_IRQ_STAT, 2);
      apb(1, OFS_IRQ_MASK, 2);
      tick(1);
      `CHK("irq", 1'b1, irq)
      apb(1, OFS_IRQ_MASK, 0);
      tick(1);
      `CHK("irq", 1'b0, irq)
      apb(1, OFS_IRQ_MASK, 2);
      apb(1, OFS_IRQ_STAT, 2);
      tick(1);
      `CHK("irq", 1'b0, irq)
      apb(0, 8'h30, 0);
      `CHK("unmapped", 33'h100000000, {err, rd})
      $display("test normal done");
      // fail-output test drive held off while measuring, back once released
      fail_signal <= 0;
      apb(1, OFS_MEAS_CTRL, 1);
      apb(1, OFS_PIN_FUNC, 32'h11);
      apb(1, OFS_PULL_CFG, PULL_AUTO);
      tick(2);
      `CHK("fail test", 4'h0, {pin_oe, pu, pd, ppd})
      rchk(OFS_IRQ_STAT, 1);
      apb(1, OFS_MEAS_CTRL, 0);
      tick(2);
      `CHK("fail test", 4'hA, {pin_oe, pu, pd, ppd})
      // high-side drive raises the pin, pin wake seen with measuring off
      apb(1, OFS_WAKE_CFG, 2);
      apb(1, OFS_PIN_FUNC, 32'h24);
      tick(8);
      `CHK("high side", 2'h3, {pin_oe, pin_o})
      rchk(OFS_WAKE_STAT1, 1);
      $display("test pin functions done");
      // reset in mid-run drops the enable and opens the switch
      apb(1, OFS_PIN_FUNC, 0);
      apb(1, OFS_MEAS_CTRL, 1);
      tick(2);
      `CHK("switch", 1'b1, sw)
      @(posedge pclk);
      presetn <= 0;
      repeat (6) @(posedge pclk);
      presetn <= 1;
      tick(1);
      `CHK("switch", 1'b0, sw)
      rchk(OFS_MEAS_CTRL, 0);
      rchk(OFS_PULL_CFG, 0);
      $display("test reset done");
      finish_test();
   end
endmodule
